// ### rtl/tgs_pkg.sv
package tgs_pkg;

  // register byte addresses
  localparam logic [7:0] TGS_ADDR_CTRL       = 8'h00;
  localparam logic [7:0] TGS_ADDR_START_IDX  = 8'h04;
  localparam logic [7:0] TGS_ADDR_STOP_IDX   = 8'h08;
  localparam logic [7:0] TGS_ADDR_START_GAIN = 8'h0C;
  localparam logic [7:0] TGS_ADDR_HOLD       = 8'h10;
  localparam logic [7:0] TGS_ADDR_RAMP_RATE  = 8'h14;
  localparam logic [7:0] TGS_ADDR_COARSE     = 8'h18;
  localparam logic [7:0] TGS_ADDR_FINE       = 8'h1C;
  localparam logic [7:0] TGS_ADDR_TAB_ADDR   = 8'h20;
  localparam logic [7:0] TGS_ADDR_TAB_DATA   = 8'h24;
  localparam logic [7:0] TGS_ADDR_STATUS     = 8'h28;

  // control and status register fields
  localparam int TGS_CTRL_SELF_TRIG  = 0;
  localparam int TGS_CTRL_LINEAR     = 1;
  localparam int TGS_CTRL_FIXED      = 2;
  localparam int TGS_CTRL_INTERP     = 3;
  localparam int TGS_CTRL_TAB_WREN   = 4;
  localparam int TGS_CTRL_SOFT_TRIG  = 5;
  localparam int TGS_STAT_ACTIVE     = 16;

  // reset values
  localparam logic [7:0] TGS_RST_BYTE = 8'h00;
  localparam logic [5:0] TGS_RST_GAIN = 6'h00;
  localparam logic [2:0] TGS_RST_FINE = 3'h0;

  // gain coding, in eighths of a dB above the -5 dB floor
  localparam logic [5:0] TGS_COARSE_MAX = 6'h24;
  localparam logic [8:0] TGS_GAIN_MAX   = 9'h127;
  localparam logic [8:0] TGS_DB_STEP    = 9'h008;
  localparam logic [8:0] TGS_FINE_STEP  = 9'h001;
  localparam logic [2:0] TGS_LAST_SUB   = 3'h7;
  localparam logic [7:0] TGS_UNIT_MIN   = 8'h01;

  typedef enum logic [1:0] {ST_IDLE, ST_STEP, ST_DWELL, ST_RETURN} tgs_state_t;

endpackage

// ### rtl/tgs_sequencer.sv
// How it works
// - self-trigger bit set: curve runs repeatedly without any trigger pin pulse
// - each self pass: walk indices, dwell at final gain, return, restart
// - register trigger taken at the write edge, engine starts next clock edge
// - async serial clock may shift register start by one sample; here clocks match
// - trigger loads initial gain code (code 6 is 1 dB), starts at first index
// - entry low byte times eight sample periods per 1 dB change
// - entry bit 8 set lowers gain by 1 dB, clear raises it
// - interpolation: eight 0.125 dB steps; otherwise frozen then 1 dB move
// - curve final gain: start plus span minus twice decrements, plus 0.875 if fine
// - linear ramp bit: constant rate rise from ramp-rate setting, table unused
// - ramp rate counts samples per 0.125 dB, or 8-sample units per 1 dB
// - ramp final gain: start plus index difference, plus 0.875 dB if fine
// - ramp uses index difference only; rises only
// - ramp, fine steps, equal indices: seven 0.125 dB steps then dwell
// - ramp, no fine steps, equal indices: hold eight times rate, then dwell
// - after dwell, gain returns toward initial gain 1 dB per sample
// - fixed gain bit: curve engine off, gain is coarse plus fine
// - coarse code 0 to 0x24 maps -5 to 31 dB; above clamps
// - fine code adds 0.125 dB per step
// - step table holds 149 nine-bit entries (addresses 0 to 148), written while write enable set
// - trigger pin sampled at rising clock edge, gain changes on that edge
// - curve stops at last index or gain limit; last gain held for dwell
`timescale 1ns/1ps
module tgs_sequencer
  import tgs_pkg::*;
#(
  parameter int TABLE_DEPTH = 148,
  parameter int HOLD_UNIT   = 33,
  parameter int DWELL_W     = 14
) (
  // clock, reset, enable
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       ce,
  // apb slave
  input  wire logic       psel,
  input  wire logic       penable,
  input  wire logic       pwrite,
  input  wire logic [7:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // trigger pin
  input  wire logic       curve_trigger,
  // gain output and curve active flag
  output logic      [8:0] gain_code,
  output logic            curve_active
);

  if (TABLE_DEPTH < 1 || TABLE_DEPTH > 255) begin : g_chk_depth
    $error("TABLE_DEPTH must be 1..255");
  end
  if (HOLD_UNIT < 1 || HOLD_UNIT * 255 >= (1 << DWELL_W)) begin : g_chk_hold
    $error("HOLD_UNIT does not fit DWELL_W");
  end

  // configuration registers
  logic [7:0]  ctrl_reg, ctrl_next;
  logic [7:0]  start_idx_reg, start_idx_next;
  logic [7:0]  stop_idx_reg, stop_idx_next;
  logic [5:0]  start_gain_reg, start_gain_next;
  logic [7:0]  hold_reg, hold_next;
  logic [7:0]  rate_reg, rate_next;
  logic [5:0]  coarse_reg, coarse_next;
  logic [2:0]  fine_reg, fine_next;
  logic [7:0]  tab_addr_reg, tab_addr_next;
  logic        soft_pulse_reg, soft_pulse_next;
  logic [31:0] prdata_reg, prdata_next;
  logic        slverr_reg, slverr_next;
  logic [8:0]  table_mem [TABLE_DEPTH + 1];

  // engine state
  tgs_state_t          state_reg, state_next;
  logic [8:0]          gain_reg, gain_next;
  logic [7:0]          ptr_reg, ptr_next;
  logic [7:0]          rem_reg, rem_next;
  logic [2:0]          sub_reg, sub_next;
  logic [7:0]          cnt_reg, cnt_next;
  logic [DWELL_W-1:0]  dwell_reg, dwell_next;

  logic                wr_access, rd_setup, tab_write, mapped;
  logic                self_trig, linear, fixed_sel, interp, tab_wren;
  logic [8:0]          entry, base_gain, fixed_gain;
  logic [7:0]          units;
  logic                dec, last, substep_end, start_hit;
  logic [9:0]          move, gain_wide;
  logic [DWELL_W-1:0]  hold_limit;

  assign self_trig = ctrl_reg[TGS_CTRL_SELF_TRIG];
  assign linear    = ctrl_reg[TGS_CTRL_LINEAR];
  assign fixed_sel = ctrl_reg[TGS_CTRL_FIXED];
  assign interp    = ctrl_reg[TGS_CTRL_INTERP];
  assign tab_wren  = ctrl_reg[TGS_CTRL_TAB_WREN];

  assign pready       = ce;
  assign prdata       = prdata_reg;
  assign pslverr      = slverr_reg;
  assign gain_code    = gain_reg;
  assign curve_active = (state_reg != ST_IDLE);

  // apb decode
  assign wr_access = ce && psel && penable && pwrite;
  assign rd_setup  = ce && psel && !penable;
  assign tab_write = wr_access && paddr == TGS_ADDR_TAB_DATA && tab_wren;

  always_comb begin
    case (paddr)
      TGS_ADDR_CTRL, TGS_ADDR_START_IDX, TGS_ADDR_STOP_IDX, TGS_ADDR_START_GAIN,
      TGS_ADDR_HOLD, TGS_ADDR_RAMP_RATE, TGS_ADDR_COARSE, TGS_ADDR_FINE,
      TGS_ADDR_TAB_ADDR, TGS_ADDR_TAB_DATA, TGS_ADDR_STATUS: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // register file next values
  always_comb begin
    ctrl_next       = ctrl_reg;
    start_idx_next  = start_idx_reg;
    stop_idx_next   = stop_idx_reg;
    start_gain_next = start_gain_reg;
    hold_next       = hold_reg;
    rate_next       = rate_reg;
    coarse_next     = coarse_reg;
    fine_next       = fine_reg;
    tab_addr_next   = tab_addr_reg;
    soft_pulse_next = 1'b0;
    prdata_next     = prdata_reg;
    slverr_next     = slverr_reg;
    if (wr_access) begin
      case (paddr)
        TGS_ADDR_CTRL: begin
          ctrl_next = {3'h0, pwdata[4:0]};
          soft_pulse_next = pwdata[TGS_CTRL_SOFT_TRIG];
        end
        TGS_ADDR_START_IDX:  start_idx_next  = pwdata[7:0];
        TGS_ADDR_STOP_IDX:   stop_idx_next   = pwdata[7:0];
        TGS_ADDR_START_GAIN: start_gain_next = pwdata[5:0];
        TGS_ADDR_HOLD:       hold_next       = pwdata[7:0];
        TGS_ADDR_RAMP_RATE:  rate_next       = pwdata[7:0];
        TGS_ADDR_COARSE:     coarse_next     = pwdata[5:0];
        TGS_ADDR_FINE:       fine_next       = pwdata[2:0];
        TGS_ADDR_TAB_ADDR:   tab_addr_next   = pwdata[7:0];
        default: ;
      endcase
    end
    if (rd_setup) begin
      slverr_next = !mapped;
      case (paddr)
        TGS_ADDR_CTRL:       prdata_next = {24'h0, ctrl_reg};
        TGS_ADDR_START_IDX:  prdata_next = {24'h0, start_idx_reg};
        TGS_ADDR_STOP_IDX:   prdata_next = {24'h0, stop_idx_reg};
        TGS_ADDR_START_GAIN: prdata_next = {26'h0, start_gain_reg};
        TGS_ADDR_HOLD:       prdata_next = {24'h0, hold_reg};
        TGS_ADDR_RAMP_RATE:  prdata_next = {24'h0, rate_reg};
        TGS_ADDR_COARSE:     prdata_next = {26'h0, coarse_reg};
        TGS_ADDR_FINE:       prdata_next = {29'h0, fine_reg};
        TGS_ADDR_TAB_ADDR:   prdata_next = {24'h0, tab_addr_reg};
        TGS_ADDR_TAB_DATA: begin
          prdata_next = 32'h0;
          if (int'(tab_addr_reg) <= TABLE_DEPTH) prdata_next = {23'h0, table_mem[tab_addr_reg]};
        end
        TGS_ADDR_STATUS: begin
          prdata_next = {23'h0, gain_reg};
          prdata_next[TGS_STAT_ACTIVE] = curve_active;
        end
        default:             prdata_next = 32'h0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg       <= TGS_RST_BYTE;
      start_idx_reg  <= TGS_RST_BYTE;
      stop_idx_reg   <= TGS_RST_BYTE;
      start_gain_reg <= TGS_RST_GAIN;
      hold_reg       <= TGS_RST_BYTE;
      rate_reg       <= TGS_RST_BYTE;
      coarse_reg     <= TGS_RST_GAIN;
      fine_reg       <= TGS_RST_FINE;
      tab_addr_reg   <= TGS_RST_BYTE;
      soft_pulse_reg <= 1'b0;
      prdata_reg     <= 32'h0;
      slverr_reg     <= 1'b0;
    end else if (ce) begin
      ctrl_reg       <= ctrl_next;
      start_idx_reg  <= start_idx_next;
      stop_idx_reg   <= stop_idx_next;
      start_gain_reg <= start_gain_next;
      hold_reg       <= hold_next;
      rate_reg       <= rate_next;
      coarse_reg     <= coarse_next;
      fine_reg       <= fine_next;
      tab_addr_reg   <= tab_addr_next;
      soft_pulse_reg <= soft_pulse_next;
      prdata_reg     <= prdata_next;
      slverr_reg     <= slverr_next;
    end
  end

  // step table storage, no reset
  always_ff @(posedge pclk) begin
    if (tab_write && int'(tab_addr_reg) <= TABLE_DEPTH) begin
      table_mem[tab_addr_reg] <= pwdata[8:0];
    end
  end

  // engine helpers
  always_comb begin
    entry = 9'h000;
    if (int'(ptr_reg) <= TABLE_DEPTH) entry = table_mem[ptr_reg];
  end
  assign units       = linear ? rate_reg : entry[7:0];
  assign dec         = !linear && entry[8];
  assign last        = (rem_reg == 8'h00);
  assign substep_end = (cnt_reg + 8'h01 >= ((units == 8'h00) ? TGS_UNIT_MIN : units));
  assign base_gain   = ((start_gain_reg > TGS_COARSE_MAX) ? TGS_COARSE_MAX : start_gain_reg) * TGS_DB_STEP;
  assign fixed_gain  = ((coarse_reg > TGS_COARSE_MAX) ? TGS_COARSE_MAX : coarse_reg) * TGS_DB_STEP
                       + {6'h00, fine_reg};
  assign hold_limit  = DWELL_W'(hold_reg) * DWELL_W'(HOLD_UNIT);
  // pin sampled here on the clock edge; soft pulse is the write one edge earlier
  assign start_hit   = !fixed_sel && (curve_trigger || soft_pulse_reg
                       || (self_trig && state_reg == ST_IDLE))
                       && state_reg != ST_STEP;

  always_comb begin
    state_next = state_reg;
    gain_next  = gain_reg;
    ptr_next   = ptr_reg;
    rem_next   = rem_reg;
    sub_next   = sub_reg;
    cnt_next   = cnt_reg;
    dwell_next = dwell_reg;
    move       = 10'h000;
    gain_wide  = {1'b0, gain_reg};
    case (state_reg)
      ST_IDLE: ;
      ST_STEP: begin
        if (!substep_end) begin
          cnt_next = cnt_reg + 8'h01;
        end else begin
          cnt_next = 8'h00;
          if (interp) move = {1'b0, TGS_FINE_STEP};
          else if (sub_reg == TGS_LAST_SUB) move = {1'b0, TGS_DB_STEP};
          if (last && sub_reg == TGS_LAST_SUB) move = 10'h000;
          gain_wide = dec ? {1'b0, gain_reg} - move : {1'b0, gain_reg} + move;
          if (gain_wide > {1'b0, TGS_GAIN_MAX}) begin
            state_next = ST_DWELL;
            dwell_next = '0;
          end else begin
            gain_next = gain_wide[8:0];
            if (sub_reg == TGS_LAST_SUB) begin
              sub_next = 3'h0;
              if (last || (!linear && int'(ptr_reg) >= TABLE_DEPTH)) begin
                state_next = ST_DWELL;
                dwell_next = '0;
              end else begin
                ptr_next = ptr_reg + 8'h01;
                rem_next = rem_reg - 8'h01;
              end
            end else begin
              sub_next = sub_reg + 3'h1;
            end
          end
        end
      end
      ST_DWELL: begin
        if (dwell_reg + DWELL_W'(1) >= hold_limit) state_next = ST_RETURN;
        else dwell_next = dwell_reg + DWELL_W'(1);
      end
      ST_RETURN: begin
        if (gain_reg > base_gain + TGS_DB_STEP) gain_next = gain_reg - TGS_DB_STEP;
        else if (gain_reg + TGS_DB_STEP < base_gain) gain_next = gain_reg + TGS_DB_STEP;
        else gain_next = base_gain;
        if (gain_reg == base_gain) state_next = ST_IDLE;
      end
      default: state_next = ST_IDLE;
    endcase
    if (start_hit) begin
      state_next = ST_STEP;
      gain_next  = base_gain;
      ptr_next   = start_idx_reg;
      rem_next   = (stop_idx_reg > start_idx_reg) ? stop_idx_reg - start_idx_reg : 8'h00;
      sub_next   = 3'h0;
      cnt_next   = 8'h00;
      dwell_next = '0;
    end
    if (fixed_sel) begin
      state_next = ST_IDLE;
      gain_next  = fixed_gain;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_IDLE;
      gain_reg  <= 9'h000;
      ptr_reg   <= 8'h00;
      rem_reg   <= 8'h00;
      sub_reg   <= 3'h0;
      cnt_reg   <= 8'h00;
      dwell_reg <= '0;
    end else if (ce) begin
      state_reg <= state_next;
      gain_reg  <= gain_next;
      ptr_reg   <= ptr_next;
      rem_reg   <= rem_next;
      sub_reg   <= sub_next;
      cnt_reg   <= cnt_next;
      dwell_reg <= dwell_next;
    end
  end

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_self_start;
    ce && !fixed_sel && self_trig && state_reg == ST_IDLE |=> state_reg == ST_STEP;
  endproperty
  a_self_start: assert property (p_self_start) else $error("self trigger did not start curve");

  property p_soft_trig;
    wr_access && paddr == TGS_ADDR_CTRL && pwdata[TGS_CTRL_SOFT_TRIG] && !pwdata[TGS_CTRL_FIXED]
      ##1 ce && state_reg != ST_STEP |=> state_reg == ST_STEP;
  endproperty
  a_soft_trig: assert property (p_soft_trig) else $error("register trigger not taken next edge");

  property p_start_gain;
    ce && start_hit && !fixed_sel |=> state_reg == ST_STEP && gain_reg == $past(base_gain)
      && ptr_reg == $past(start_idx_reg);
  endproperty
  a_start_gain: assert property (p_start_gain) else $error("start did not load initial gain");

  property p_pin_trig;
    ce && curve_trigger && !fixed_sel && state_reg != ST_STEP |=> state_reg == ST_STEP;
  endproperty
  a_pin_trig: assert property (p_pin_trig) else $error("pin trigger not taken");

  property p_frozen;
    ce && state_reg == ST_STEP && !interp && sub_reg != TGS_LAST_SUB && !start_hit && !fixed_sel
      |=> gain_reg == $past(gain_reg);
  endproperty
  a_frozen: assert property (p_frozen) else $error("gain moved while frozen");

  property p_return;
    ce && state_reg == ST_RETURN && gain_reg > base_gain + TGS_DB_STEP && !start_hit && !fixed_sel
      |=> gain_reg == $past(gain_reg) - TGS_DB_STEP;
  endproperty
  a_return: assert property (p_return) else $error("return step not 1 dB");

  property p_fixed;
    ce && fixed_sel |=> gain_reg == $past(fixed_gain) && state_reg == ST_IDLE;
  endproperty
  a_fixed: assert property (p_fixed) else $error("fixed gain not applied");

  property p_coarse_clamp;
    ce && fixed_sel && coarse_reg > TGS_COARSE_MAX |=> gain_reg[8:3] == TGS_COARSE_MAX;
  endproperty
  a_coarse_clamp: assert property (p_coarse_clamp) else $error("coarse code not clamped");

  property p_gain_range;
    gain_reg <= TGS_GAIN_MAX;
  endproperty
  a_gain_range: assert property (p_gain_range) else $error("gain beyond limit");

  property p_table_write;
    tab_write && int'(tab_addr_reg) <= TABLE_DEPTH |=> table_mem[$past(tab_addr_reg)] == $past(pwdata[8:0]);
  endproperty
  a_table_write: assert property (p_table_write) else $error("table entry not stored");

  c_dwell:   cover property (state_reg == ST_STEP ##1 state_reg == ST_DWELL);
  c_restart: cover property (state_reg == ST_RETURN && start_hit);
  c_loop:    cover property (self_trig && state_reg == ST_RETURN ##1 state_reg == ST_IDLE ##1 state_reg == ST_STEP);
  c_linear:  cover property (linear && interp && state_reg == ST_DWELL);

endmodule // tgs_sequencer

// ### dv/tgs_ctrl_model.sv
`timescale 1ns/1ps
// controller model: apb master and trigger pin driver
module tgs_ctrl_model (
  // clock
  input  wire logic        pclk,
  // apb master
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  // trigger pin
  output logic             curve_trigger
);
  initial begin
    psel          = 1'b0;
    penable       = 1'b0;
    pwrite        = 1'b0;
    paddr         = 8'h00;
    pwdata        = 32'h0000_0000;
    curve_trigger = 1'b0;
  end

  // one transfer; the request stands until pready is seen high
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // released lines carry a changed pattern, not the last value
    paddr   <= ~a;
    pwdata  <= ~d;
  endtask

  // one-cycle high pulse, sampled at the following rising edge
  task automatic pulse();
    @(posedge pclk);
    curve_trigger <= 1'b1;
    @(posedge pclk);
    curve_trigger <= 1'b0;
  endtask
endmodule // tgs_ctrl_model

// ### dv/test_tgs_sequencer.sv
`timescale 1ns/1ps
module test_tgs_sequencer;
  import tgs_pkg::*;
  localparam int HU    = 2;
  localparam int HOLDV = 4;
  localparam int DW    = HU * HOLDV;
  localparam logic [31:0] SELF = 32'h01, LIN = 32'h02, FIX = 32'h04, INT = 32'h08, TWE = 32'h10, SOFT = 32'h20;
  logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, curve_trigger, curve_active;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [8:0]  gain_code;
  logic        rerr;
  int          error_cnt, cmp_count, cyc, last_cyc, exp_g, t;
  logic [31:0] fc [4] = '{32'h25, 32'h24, 32'h00, 32'h0A};
  logic [31:0] ff [4] = '{32'h7, 32'h0, 32'h3, 32'h5};
  logic [31:0] fe [4] = '{32'h127, 32'h120, 32'h003, 32'h055};
  logic [31:0] tab [8] = '{32'h004, 32'h00F, 32'h008, 32'h005, 32'h108, 32'h007, 32'h00A, 32'h00F};

  tgs_sequencer #(.HOLD_UNIT(HU)) i_tgs_sequencer (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .curve_trigger(curve_trigger), .gain_code(gain_code), .curve_active(curve_active));

  tgs_ctrl_model i_tgs_ctrl_model (
    .pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .curve_trigger(curve_trigger));

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      summarize();
    end
  end

  task automatic summarize();
    $display("mismatches %0d of %0d compares", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_tgs_ctrl_model.xfer(1'b1, a, d, rdat, rerr);
  endtask

  task automatic rd(input logic [7:0] a);
    i_tgs_ctrl_model.xfer(1'b0, a, 32'h0, rdat, rerr);
  endtask

  task automatic cfg(input logic [31:0] c, input int s, input int i0, input int i1, input int rate);
    wr(TGS_ADDR_CTRL, c);
    wr(TGS_ADDR_START_IDX, i0);
    wr(TGS_ADDR_STOP_IDX, i1);
    wr(TGS_ADDR_START_GAIN, s);
    wr(TGS_ADDR_HOLD, HOLDV);
    wr(TGS_ADDR_RAMP_RATE, rate);
    exp_g = s * 8;
  endtask

  // curve just started: gain at the initial code
  task automatic mark();
    check(gain_code, exp_g);
    check(curve_active, 1);
    last_cyc = cyc;
  endtask

  task automatic go();
    i_tgs_ctrl_model.pulse();
    #1;
    mark();
  endtask

  task automatic wait_chg(output int dt);
    logic [8:0] g0;
    g0 = gain_code;
    do begin
      @(posedge pclk);
      #1;
    end while (gain_code === g0);
    dt = cyc - last_cyc;
    last_cyc = cyc;
  endtask

  task automatic moves(input int n, input int dt, input int step);
    int k;
    repeat (n) begin
      wait_chg(k);
      exp_g = exp_g + step;
      check(k, dt);
      check(gain_code, exp_g);
    end
  endtask

  // dwell after the final hold, then 1 dB per cycle back to base
  task automatic ret(input int pre, input int base);
    int k;
    int first;
    first = 1;
    do begin
      wait_chg(k);
      if (first == 1) begin
        check(k >= pre + DW && k <= pre + DW + 2, 1);
      end else begin
        check(k, 1);
      end
      first = 0;
      exp_g = (exp_g - 8 > base) ? exp_g - 8 : base;
      check(gain_code, exp_g);
    end while (exp_g > base);
    k = 0;
    while (curve_active === 1'b1 && k < 4) begin
      @(posedge pclk);
      #1;
      k++;
    end
    check(curve_active, 0);
  endtask

  initial begin
    presetn   = 1'b0;
    ce        = 1'b1;
    error_cnt = 0;
    cmp_count = 0;
    cyc       = 0;
    last_cyc  = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    #1;
    check(gain_code, 0);
    wr(TGS_ADDR_START_IDX, 32'h5);
    rd(TGS_ADDR_START_IDX);
    check(rdat, 32'h5);
    rd(8'h40);
    check(rerr, 1);
    check(rdat, 0);
    // fixed gain, coarse clamp and fine steps
    for (int k = 0; k < 4; k++) begin
      wr(TGS_ADDR_CTRL, FIX);
      wr(TGS_ADDR_COARSE, fc[k]);
      wr(TGS_ADDR_FINE, ff[k]);
      repeat (2) @(posedge pclk);
      #1;
      check(gain_code, fe[k]);
    end
    rd(TGS_ADDR_STATUS);
    check(rdat, fe[3]);
    i_tgs_ctrl_model.pulse();
    @(posedge pclk);
    #1;
    check(curve_active, 0);
    // step table, curve from entry 2 to 7
    wr(TGS_ADDR_CTRL, TWE);
    for (int k = 0; k < 8; k++) begin
      wr(TGS_ADDR_TAB_ADDR, k + 1);
      wr(TGS_ADDR_TAB_DATA, tab[k]);
    end
    rd(TGS_ADDR_TAB_DATA);
    check(rdat, tab[7]);
    cfg(INT, 6, 2, 7, 1);
    go();
    moves(8, 15, 1);
    moves(8, 8, 1);
    moves(8, 5, 1);
    moves(8, 8, -1);
    moves(8, 7, 1);
    moves(7, 10, 1);
    check(gain_code, (6 + 5 - 2) * 8 + 7);
    ret(10, 48);
    cfg(0, 6, 2, 3, 1);
    go();
    moves(1, 120, 8);
    check(gain_code, (6 + 1) * 8);
    ret(64, 48);
    // linear ramps
    cfg(LIN | INT, 2, 0, 0, 1);
    go();
    moves(7, 1, 1);
    ret(1, 16);
    cfg(LIN, 2, 0, 2, 2);
    go();
    moves(2, 16, 8);
    check(gain_code, (2 + 2) * 8);
    ret(16, 16);
    cfg(LIN | INT, 2, 4, 5, 3);
    go();
    moves(15, 3, 1);
    check(gain_code, (2 + 1) * 8 + 7);
    ret(3, 16);
    cfg(LIN, 2, 0, 0, 3);
    go();
    t = 0;
    while (curve_active === 1'b1 && t < 200) begin
      @(posedge pclk);
      #1;
      t++;
    end
    check(t >= 24 + DW && t <= 24 + DW + 3, 1);
    check(gain_code, 16);
    // register trigger, then pin trigger during the dwell
    cfg(LIN | INT, 2, 0, 0, 1);
    wr(TGS_ADDR_CTRL, LIN | INT | SOFT);
    @(posedge pclk);
    #1;
    mark();
    moves(7, 1, 1);
    repeat (3) @(posedge pclk);
    exp_g = 16;
    go();
    moves(7, 1, 1);
    ret(1, 16);
    // self-triggered passes
    wr(TGS_ADDR_CTRL, SELF | LIN | INT);
    t = 0;
    while (curve_active !== 1'b1 && t < 10) begin
      @(posedge pclk);
      #1;
      t++;
    end
    mark();
    moves(7, 1, 1);
    ret(1, 16);
    wait_chg(t);
    check(gain_code, 17);
    wr(TGS_ADDR_CTRL, LIN | INT);
    t = 0;
    while (curve_active === 1'b1 && t < 100) begin
      @(posedge pclk);
      #1;
      t++;
    end
    check(curve_active, 0);
    repeat (3) @(posedge pclk);
    #1;
    check(curve_active, 0);
    // clock enable low freezes the engine and stalls the bus
    cfg(LIN | INT, 2, 0, 0, 1);
    go();
    @(posedge pclk);
    ce <= 1'b0;
    repeat (4) @(posedge pclk);
    #1;
    check(gain_code, 17);
    check(pready, 0);
    @(posedge pclk);
    ce <= 1'b1;
    #1;
    last_cyc = cyc;
    exp_g = 17;
    moves(6, 1, 1);
    ret(1, 16);
    summarize();
  end
endmodule // test_tgs_sequencer
